// >>> logic/csa_pkg.sv
// Shared constants: sideband and descriptor bits, register map, slice state.
// Assumes both ends are clocked by one core user clock.
package csa_pkg;
   localparam int MAX_W        = 256;
   localparam int STRADDLE_W   = 256;
   localparam int RC_SB_W      = 75;
   localparam int CC_SB_W      = 33;
   localparam int SB_BE_LSB    = 0;
   localparam int SB_BE_W      = 32;
   localparam int SB_SOP0      = 32;
   localparam int SB_SOP1      = 33;
   localparam int SB_EOF0_LSB  = 34;
   localparam int SB_EOF1_LSB  = 38;
   localparam int SB_EOF_W     = 4;
   localparam int SB_DISC      = 41;
   localparam int CC_SB_DISC   = 0;
   localparam int DESC_POISON  = 46;
   localparam int DESC_ECRC    = 95;
   localparam int DESC_BC_LSB  = 16;
   localparam int SOP1_OFFSET  = 128;
   localparam int TALLY_W      = 2;
   localparam int CNT_W        = 16;
   // Controller registers
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK   = 8'h08;
   localparam logic [7:0] REG_COUNT  = 8'h0c;
   localparam int CTRL_ECRC     = 0;
   localparam int CTRL_POISON   = 1;
   localparam int CTRL_ASK      = 2;
   localparam int CTRL_TALLY    = 4;
   localparam int EV_W          = 3;
   localparam int EV_END        = 0;
   localparam int EV_POISON     = 1;
   localparam int EV_DISC       = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {SL_EMPTY = 2'b01, SL_FULL = 2'b10} csa_slice_t;

   // Final dword byte mask from byte count
   function automatic logic [3:0] csa_last_mask(input logic [1:0] bc);
      unique case (bc)
         2'h1:    csa_last_mask = 4'h1;
         2'h2:    csa_last_mask = 4'h3;
         2'h3:    csa_last_mask = 4'h7;
         default: csa_last_mask = 4'hf;
      endcase
   endfunction : csa_last_mask

   // Keep to byte strobe; last beat trims top kept dword
   function automatic logic [MAX_W/8-1:0] csa_strobe(input logic [MAX_W/32-1:0] keep,
                                                     input logic [1:0] bc,
                                                     input logic last);
      logic [MAX_W/8-1:0] s;
      s = '0;
      for (int i = 0; i < MAX_W/32; i++)
      begin
         if (keep[i])
            s[4*i +: 4] = 4'hf;
         if (last && keep[i] && (i == MAX_W/32-1 || !keep[i+1 < MAX_W/32 ? i+1 : i]))
            s[4*i +: 4] = csa_last_mask(bc);
      end
      csa_strobe = s;
   endfunction : csa_strobe
endpackage : csa_pkg

// >>> logic/csa_link_if.sv
// Completion streams between core end and user end.
// Assumes one clock for both ends.
`timescale 1ns/1ps
`default_nettype none
interface csa_link_if #(parameter int W = 256);
   import csa_pkg::*;
   logic [W-1:0]         rcPayload;
   logic [W/32-1:0]      rcKeep;
   logic [RC_SB_W-1:0]   rcSideband;
   logic                 rcLast;
   logic                 rcValid;
   logic                 rcReady;
   logic [W-1:0]         ccPayload;
   logic [W/32-1:0]      ccKeep;
   logic [CC_SB_W-1:0]   ccSideband;
   logic                 ccLast;
   logic                 ccValid;
   logic                 ccReady;
   logic                 nonpostedAsk;
   logic [TALLY_W-1:0]   nonpostedTally;

   modport device (output rcPayload, rcKeep, rcSideband, rcLast, rcValid, input rcReady,
                   input ccPayload, ccKeep, ccSideband, ccLast, ccValid, output ccReady,
                   input nonpostedAsk, nonpostedTally);
   modport user   (input rcPayload, rcKeep, rcSideband, rcLast, rcValid, output rcReady,
                   output ccPayload, ccKeep, ccSideband, ccLast, ccValid, input ccReady,
                   output nonpostedAsk, nonpostedTally);
endinterface : csa_link_if
`default_nettype wire

// >>> logic/csa_core_end.sv
// Core end: source beats onto the requester completion stream,
// completer completion beats onto the legacy transmit port.
// Assumes inputs synchronous to clk; each slice moves a beat per two cycles.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Completions for own requests leave on dedicated stream
// - Completion stream keeps last/valid/ready/data meaning
// - Nonposted pacing only via ask and tally
// - Keep per dword, byte enables sideband 31:0
// - Discontinue 41, first start 32, end 37:34
// - Straddle lets 256-bit beat hold two packets
// - Second start/end used only when straddling
// - Poison bit 46 read only on start beats
// - No region hit indication on completions
// - Reply stream keeps last/valid/ready/data meaning
// - Last dword bytes from keep plus count
// - Non-last keep marks whole dwords only
// - ECRC bit 95, poison 46, discontinue sideband 0
module csa_core_end #(
   parameter int W        = 256,
   parameter bit STRADDLE = 1'b0
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   csa_link_if.device                  link,
   input  wire logic [W-1:0]           srcPayload,
   input  wire logic [W/32-1:0]        srcKeep,
   input  wire logic [31:0]            srcByteEn,
   input  wire logic                   srcFirstStart,
   input  wire logic                   srcSecondStart,
   input  wire logic [3:0]             srcFirstEnd,
   input  wire logic [3:0]             srcSecondEnd,
   input  wire logic                   srcEcrcErr,
   input  wire logic                   srcLast,
   input  wire logic                   srcValid,
   output logic                        srcReady,
   output logic [W-1:0]                txPayload,
   output logic [W/8-1:0]              txStrobe,
   output logic                        txLast,
   output logic                        txValid,
   input  wire logic                   txReady,
   output logic                        txEcrcGen,
   output logic                        txErrFwd,
   output logic                        txDiscontinue,
   output logic                        nonpostedAsk,
   output logic [csa_pkg::TALLY_W-1:0] nonpostedTally
);
   import csa_pkg::*;
   localparam bit USE_SECOND = STRADDLE && (W == STRADDLE_W);
   localparam int ECRC_BEAT  = DESC_ECRC / W;
   localparam int ECRC_POS   = DESC_ECRC % W;

   ////////////////////////////////////////////////////////////////////////
   // Requester completion slice
   csa_slice_t           rcState, next_rcState;
   logic [W-1:0]         rcPayload, next_rcPayload;
   logic [W/32-1:0]      rcKeep, next_rcKeep;
   logic [RC_SB_W-1:0]   rcSideband, next_rcSideband;
   logic                 rcLast, next_rcLast;
   logic                 next_srcReady;

   always_comb
   begin
      next_rcState    = rcState;
      next_rcPayload  = rcPayload;
      next_rcKeep     = rcKeep;
      next_rcSideband = rcSideband;
      next_rcLast     = rcLast;
      unique case (rcState)
         SL_EMPTY:
            if (srcValid && srcReady)
            begin
               next_rcState    = SL_FULL;
               next_rcPayload  = srcPayload;
               next_rcKeep     = srcKeep;
               next_rcLast     = srcLast;
               next_rcSideband = '0;
               next_rcSideband[SB_BE_LSB +: SB_BE_W] = srcByteEn;
               next_rcSideband[SB_SOP0] = srcFirstStart;
               next_rcSideband[SB_EOF0_LSB +: SB_EOF_W] = srcFirstEnd;
               // Legacy ECRC error has no exact match; discontinue stands in unless straddling, where second end bit 3 overwrites it
               next_rcSideband[SB_DISC] = srcEcrcErr;
               if (USE_SECOND)
               begin
                  next_rcSideband[SB_SOP1] = srcSecondStart;
                  next_rcSideband[SB_EOF1_LSB +: SB_EOF_W] = srcSecondEnd;
               end
            end
         SL_FULL:
            if (link.rcReady)
               next_rcState = SL_EMPTY;
      endcase
      next_srcReady = (next_rcState == SL_EMPTY);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rcState    <= SL_EMPTY;
         rcPayload  <= '0;
         rcKeep     <= '0;
         rcSideband <= '0;
         rcLast     <= 1'b0;
         srcReady   <= 1'b0;
      end
      else
      begin
         rcState    <= next_rcState;
         rcPayload  <= next_rcPayload;
         rcKeep     <= next_rcKeep;
         rcSideband <= next_rcSideband;
         rcLast     <= next_rcLast;
         srcReady   <= next_srcReady;
      end
   end

   assign link.rcPayload  = rcPayload;
   assign link.rcKeep     = rcKeep;
   assign link.rcSideband = rcSideband;
   assign link.rcLast     = rcLast;
   assign link.rcValid    = (rcState == SL_FULL);

   ////////////////////////////////////////////////////////////////////////
   // Completer completion slice to legacy beats
   csa_slice_t           ccState, next_ccState;
   logic [2:0]           beatIdx, next_beatIdx;
   logic [1:0]           byteCountLow, next_byteCountLow;
   logic [1:0]           bcNow;
   logic [MAX_W/32-1:0]  keepWide;
   logic [MAX_W/8-1:0]   strobeWide;
   logic [W-1:0]         next_txPayload;
   logic [W/8-1:0]       next_txStrobe;
   logic                 next_txLast, next_txEcrcGen, next_txErrFwd, next_txDiscontinue;
   logic                 next_ccReady, ccReady;

   always_comb
   begin
      next_ccState       = ccState;
      next_beatIdx       = beatIdx;
      next_byteCountLow  = byteCountLow;
      next_txPayload     = txPayload;
      next_txStrobe      = txStrobe;
      next_txLast        = txLast;
      next_txEcrcGen     = txEcrcGen;
      next_txErrFwd      = txErrFwd;
      next_txDiscontinue = txDiscontinue;
      bcNow    = (beatIdx == 3'h0) ? link.ccPayload[DESC_BC_LSB +: 2] : byteCountLow;
      keepWide = '0;
      keepWide[W/32-1:0] = link.ccKeep;
      strobeWide = csa_strobe(keepWide, bcNow, link.ccLast);
      unique case (ccState)
         SL_EMPTY:
            if (link.ccValid && ccReady)
            begin
               next_ccState       = SL_FULL;
               next_txPayload     = link.ccPayload;
               next_txStrobe      = strobeWide[W/8-1:0];
               next_txLast        = link.ccLast;
               next_txDiscontinue = link.ccSideband[CC_SB_DISC];
               if (beatIdx == 3'h0)
               begin
                  next_byteCountLow = link.ccPayload[DESC_BC_LSB +: 2];
                  next_txErrFwd     = link.ccPayload[DESC_POISON];
                  next_txEcrcGen    = 1'b0;
               end
               if (beatIdx == 3'(ECRC_BEAT))
                  next_txEcrcGen = link.ccPayload[ECRC_POS];
               next_beatIdx = link.ccLast ? 3'h0
                            : (beatIdx == 3'h7 ? beatIdx : beatIdx + 3'h1);
            end
         SL_FULL:
            if (txReady)
               next_ccState = SL_EMPTY;
      endcase
      next_ccReady = (next_ccState == SL_EMPTY);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ccState       <= SL_EMPTY;
         beatIdx       <= 3'h0;
         byteCountLow  <= 2'h0;
         txPayload     <= '0;
         txStrobe      <= '0;
         txLast        <= 1'b0;
         txEcrcGen     <= 1'b0;
         txErrFwd      <= 1'b0;
         txDiscontinue <= 1'b0;
         ccReady       <= 1'b0;
      end
      else
      begin
         ccState       <= next_ccState;
         beatIdx       <= next_beatIdx;
         byteCountLow  <= next_byteCountLow;
         txPayload     <= next_txPayload;
         txStrobe      <= next_txStrobe;
         txLast        <= next_txLast;
         txEcrcGen     <= next_txEcrcGen;
         txErrFwd      <= next_txErrFwd;
         txDiscontinue <= next_txDiscontinue;
         ccReady       <= next_ccReady;
      end
   end

   assign txValid      = (ccState == SL_FULL);
   assign link.ccReady = ccReady;

   ////////////////////////////////////////////////////////////////////////
   // Nonposted pacing comes only from the request side, never from completions
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nonpostedAsk   <= 1'b0;
         nonpostedTally <= '0;
      end
      else
      begin
         nonpostedAsk   <= link.nonpostedAsk;
         nonpostedTally <= link.nonpostedTally;
      end
   end
endmodule : csa_core_end
`default_nettype wire

// >>> logic/csa_user_end.sv
// User end: takes requester completions, sends completer completions,
// reports over APB registers with one interrupt.
// Assumes an APB master and inputs synchronous to clk.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csa_user_end #(
   parameter int W = 256
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   csa_link_if.user                    link,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        irq,
   output logic [W-1:0]                rxPayload,
   output logic                        rxValid,
   output logic                        rxLast,
   output logic                        rxPoisoned,
   input  wire logic [W-1:0]           appPayload,
   input  wire logic [W/32-1:0]        appKeep,
   input  wire logic                   appLast,
   input  wire logic                   appAbort,
   input  wire logic                   appValid,
   output logic                        appReady
);
   import csa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Requester completion receive, ready after reset
   logic              startBeat, rcTake;
   logic              next_rxPoisoned;
   logic [EV_W-1:0]   events;

   always_comb
   begin
      rcTake    = link.rcValid && link.rcReady;
      startBeat = link.rcSideband[SB_SOP0] || link.rcSideband[SB_SOP1];
      next_rxPoisoned = rxPoisoned;
      if (rcTake && startBeat)
      begin
         if (link.rcSideband[SB_SOP0])
            next_rxPoisoned = link.rcPayload[DESC_POISON];
         else if (W > SOP1_OFFSET + DESC_POISON)
            next_rxPoisoned = link.rcPayload[(SOP1_OFFSET + DESC_POISON) % W];
      end
      events = '0;
      events[EV_END]    = rcTake && link.rcLast;
      events[EV_POISON] = rcTake && startBeat && next_rxPoisoned;
      events[EV_DISC]   = rcTake && link.rcSideband[SB_DISC];
   end

   logic rcReadyReg;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rcReadyReg <= 1'b0;
         rxPayload  <= '0;
         rxValid    <= 1'b0;
         rxLast     <= 1'b0;
         rxPoisoned <= 1'b0;
      end
      else
      begin
         rcReadyReg <= 1'b1;
         rxPayload  <= rcTake ? link.rcPayload : rxPayload;
         rxValid    <= rcTake;
         rxLast     <= rcTake && link.rcLast;
         rxPoisoned <= next_rxPoisoned;
      end
   end
   assign link.rcReady = rcReadyReg;

   ////////////////////////////////////////////////////////////////////////
   // APB registers
   logic [31:0]       ctrl, next_ctrl;
   logic [EV_W-1:0]   status, next_status, mask, next_mask;
   logic [CNT_W-1:0]  count, next_count;
   logic [31:0]       next_prdata;
   logic              next_pready, next_pslverr, wrDone, mapped;

   always_comb
   begin
      wrDone  = psel && penable && pready && pwrite;
      mapped  = (paddr == REG_CTRL) || (paddr == REG_STATUS)
             || (paddr == REG_MASK) || (paddr == REG_COUNT);
      next_ctrl   = ctrl;
      next_ctrl[CTRL_ASK] = 1'b0;
      next_mask   = mask;
      next_status = status;
      if (wrDone && paddr == REG_CTRL)
         next_ctrl = pwdata;
      if (wrDone && paddr == REG_MASK)
         next_mask = pwdata[EV_W-1:0];
      if (wrDone && paddr == REG_STATUS)
         next_status = status & ~pwdata[EV_W-1:0];
      next_status = next_status | events;
      next_count  = events[EV_END] ? count + CNT_W'(1) : count;
      next_pready  = psel && !penable;
      next_pslverr = psel && !penable && !mapped;
      next_prdata  = '0;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            REG_CTRL:   next_prdata = ctrl;
            REG_STATUS: next_prdata[EV_W-1:0] = status;
            REG_MASK:   next_prdata[EV_W-1:0] = mask;
            REG_COUNT:  next_prdata[CNT_W-1:0] = count;
            default:    next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl    <= CTRL_RESET;
         status  <= '0;
         mask    <= '0;
         count   <= '0;
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end
      else
      begin
         ctrl    <= next_ctrl;
         status  <= next_status;
         mask    <= next_mask;
         count   <= next_count;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         irq     <= |(next_status & next_mask);
      end
   end

   // Nonposted pacing only through ask and tally
   assign link.nonpostedAsk   = ctrl[CTRL_ASK];
   assign link.nonpostedTally = ctrl[CTRL_TALLY +: TALLY_W];

   ////////////////////////////////////////////////////////////////////////
   // Completer completion send, half rate
   csa_slice_t          ccState, next_ccState;
   logic                firstBeat, next_firstBeat;
   logic [W-1:0]        ccPayload, next_ccPayload;
   logic [W/32-1:0]     ccKeep, next_ccKeep;
   logic                ccLast, next_ccLast, ccDisc, next_ccDisc, next_appReady;

   always_comb
   begin
      next_ccState   = ccState;
      next_firstBeat = firstBeat;
      next_ccPayload = ccPayload;
      next_ccKeep    = ccKeep;
      next_ccLast    = ccLast;
      next_ccDisc    = ccDisc;
      unique case (ccState)
         SL_EMPTY:
            if (appValid && appReady)
            begin
               next_ccState   = SL_FULL;
               next_ccPayload = appPayload;
               next_ccKeep    = appKeep;
               next_ccLast    = appLast;
               next_ccDisc    = appAbort;
               if (firstBeat)
               begin
                  next_ccPayload[DESC_POISON] = ctrl[CTRL_POISON];
                  if (W > DESC_ECRC)
                     next_ccPayload[DESC_ECRC % W] = ctrl[CTRL_ECRC];
               end
               else if (W <= DESC_ECRC && W > DESC_ECRC - W)
                  next_ccPayload[DESC_ECRC % W] = ctrl[CTRL_ECRC];
               next_firstBeat = appLast;
            end
         SL_FULL:
            if (link.ccReady)
               next_ccState = SL_EMPTY;
      endcase
      next_appReady = (next_ccState == SL_EMPTY);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ccState   <= SL_EMPTY;
         firstBeat <= 1'b1;
         ccPayload <= '0;
         ccKeep    <= '0;
         ccLast    <= 1'b0;
         ccDisc    <= 1'b0;
         appReady  <= 1'b0;
      end
      else
      begin
         ccState   <= next_ccState;
         firstBeat <= next_firstBeat;
         ccPayload <= next_ccPayload;
         ccKeep    <= next_ccKeep;
         ccLast    <= next_ccLast;
         ccDisc    <= next_ccDisc;
         appReady  <= next_appReady;
      end
   end

   always_comb
   begin
      link.ccSideband = '0;
      link.ccSideband[CC_SB_DISC] = ccDisc;
   end
   assign link.ccPayload = ccPayload;
   assign link.ccKeep    = ccKeep;
   assign link.ccLast    = ccLast;
   assign link.ccValid   = (ccState == SL_FULL);
endmodule : csa_user_end
`default_nettype wire

// >>> sim/csa_link_sva.sv
// Checker on the completion link between the two ends.
// Assumes one clock, synchronous active-high reset, no straddling.
`timescale 1ns/1ps
`default_nettype none
module csa_link_sva (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [74:0] rcSideband,
   input  wire logic        rcLast,
   input  wire logic        rcValid,
   input  wire logic        rcReady,
   input  wire logic [32:0] ccSideband,
   input  wire logic        ccLast,
   input  wire logic        ccValid,
   input  wire logic        ccReady
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   property p_rcHold;
      rcValid && !rcReady |=> rcValid && $stable(rcSideband) && $stable(rcLast);
   endproperty
   a_rcHold: assert property (p_rcHold) else $error("rc beat moved");
   property p_ccHold;
      ccValid && !ccReady |=> ccValid && $stable(ccSideband) && $stable(ccLast);
   endproperty
   a_ccHold: assert property (p_ccHold) else $error("cc beat moved");
   property p_rcGap;
      rcValid && rcReady |=> !rcValid;
   endproperty
   a_rcGap: assert property (p_rcGap) else $error("rc valid kept");
   property p_ccGap;
      ccValid && ccReady |=> !ccReady;
   endproperty
   a_ccGap: assert property (p_ccGap) else $error("cc ready kept");
   property p_noSecond;
      rcValid |-> !rcSideband[33] && rcSideband[40:38] == 3'h0;
   endproperty
   a_noSecond: assert property (p_noSecond) else $error("second fields set");
   property p_spare;
      rcValid |-> rcSideband[74:42] == 33'h0;
   endproperty
   a_spare: assert property (p_spare) else $error("spare bits set");
   property p_wake;
      $fell(rst) |-> ##[0:1] (rcReady && ccReady);
   endproperty
   a_wake: assert property (p_wake) else $error("ready late");
   property p_ccDrop;
      $fell(ccValid) |-> $past(ccReady);
   endproperty
   a_ccDrop: assert property (p_ccDrop) else $error("cc valid dropped");
endmodule : csa_link_sva
`default_nettype wire

// >>> sim/tb_top.sv
// Bench: random beats both ways between the two ends, plus APB.
// Assumes W=256, no straddling.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import csa_pkg::*;
   logic [255:0] srcPayload, txPayload, rxPayload, appPayload, p;
   logic [7:0]   srcKeep, appKeep, paddr;
   logic [31:0]  srcByteEn, txStrobe, pwdata, prdata, rd;
   logic [3:0]   srcFirstEnd, srcSecondEnd;
   logic [1:0]   tallyOut, ctrl, bc, fw;
   logic [2:0]   expSt;
   logic clk, rst, srcFirstStart, srcSecondStart, srcEcrcErr, srcLast, srcValid, srcReady;
   logic txLast, txValid, txReady, txEcrcGen, txErrFwd, txDiscontinue, askOut, er;
   logic psel, penable, pwrite, pready, pslverr, irq, rxValid, rxLast, rxPoisoned;
   logic appLast, appAbort, appValid, appReady, curPois, ccFirst;
   int err_count, comparisons, seed, asks, lastCnt;
   logic [83:0]  qRc[$];
   logic [257:0] qRx[$];
   logic [291:0] qTx[$];
   csa_link_if #(.W(256)) link();
   csa_core_end #(.W(256)) i_csa_core_end (.clk(clk), .rst(rst), .link(link),
      .srcPayload(srcPayload), .srcKeep(srcKeep), .srcByteEn(srcByteEn),
      .srcFirstStart(srcFirstStart), .srcSecondStart(srcSecondStart), .srcLast(srcLast),
      .srcFirstEnd(srcFirstEnd), .srcSecondEnd(srcSecondEnd), .srcEcrcErr(srcEcrcErr),
      .srcValid(srcValid), .srcReady(srcReady), .txPayload(txPayload), .txStrobe(txStrobe),
      .txLast(txLast), .txValid(txValid), .txReady(txReady), .txEcrcGen(txEcrcGen),
      .txErrFwd(txErrFwd), .txDiscontinue(txDiscontinue), .nonpostedAsk(askOut),
      .nonpostedTally(tallyOut));
   csa_user_end #(.W(256)) i_csa_user_end (.clk(clk), .rst(rst), .link(link), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .rxPayload(rxPayload), .rxValid(rxValid),
      .rxLast(rxLast), .rxPoisoned(rxPoisoned), .appPayload(appPayload), .appKeep(appKeep),
      .appLast(appLast), .appAbort(appAbort), .appValid(appValid), .appReady(appReady));
   csa_link_sva i_csa_link_sva (.clk(clk), .rst(rst), .rcSideband(link.rcSideband),
      .rcLast(link.rcLast), .rcValid(link.rcValid), .rcReady(link.rcReady),
      .ccSideband(link.ccSideband), .ccLast(link.ccLast), .ccValid(link.ccValid),
      .ccReady(link.ccReady));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [511:0] got, input logic [511:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (!pready);
      rd = prdata; er = pslverr; psel <= 0; penable <= 0;
      @(posedge clk);
   endtask : apb
   function automatic logic [255:0] rnd();
      for (int i = 0; i < 8; i++) rnd[32*i +: 32] = $random(seed);
   endfunction : rnd
   // Last beat trims top kept dword
   function automatic logic [31:0] strb(input logic [7:0] k, input logic [1:0] b, input logic l);
      strb = '0;
      for (int i = 0; i < 8; i++)
         if (k[i]) strb[4*i +: 4] = (l && (i == 7 || !k[i+1]) && b != 0) ? 4'hf >> (4 - b) : 4'hf;
   endfunction : strb
   task automatic rcBeat(input logic c);
      logic [31:0] r;
      logic [255:0] d;
      r = $random(seed) | (c ? 32'h308 : 32'h0); d = rnd(); d[46] = d[46] | c;
      srcPayload <= d; srcKeep <= 8'hff >> r[2:0]; srcByteEn <= r; srcFirstStart <= r[3];
      srcFirstEnd <= r[7:4]; srcEcrcErr <= r[8]; srcLast <= r[9]; srcSecondStart <= r[10];
      srcSecondEnd <= r[14:11]; srcValid <= 1;
      if (r[3]) curPois = d[46];
      qRc.push_back({r[9], 8'hff >> r[2:0], 33'h0, r[8], 3'h0, r[7:4], 1'b0, r[3], r});
      qRx.push_back({r[9], curPois, d});
      expSt |= {r[8], r[3] & d[46], r[9]}; lastCnt += r[9];
      do @(posedge clk); while (!srcReady);
   endtask : rcBeat
   task automatic ccBeat(input logic fin);
      logic [31:0] r;
      logic [255:0] d;
      r = $random(seed) | {28'h0, fin, 3'h0}; d = rnd(); p = d;
      if (ccFirst) {p[46], p[95], bc, fw} = {ctrl, d[17:16], ctrl[0], ctrl[1]};
      appPayload <= d; appKeep <= 8'hff >> r[2:0]; appLast <= r[3]; appAbort <= r[4];
      appValid <= 1;
      qTx.push_back({r[4], fw, r[3], strb(8'hff >> r[2:0], bc, r[3]), p});
      ccFirst = r[3];
      do @(posedge clk); while (!appReady);
   endtask : ccBeat
   task automatic print_verdict();
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (link.rcValid && link.rcReady) chk({link.rcLast, link.rcKeep, link.rcSideband}, qRc.pop_front());
      if (rxValid) chk({rxLast, rxPoisoned, rxPayload}, qRx.pop_front());
      if (txValid && txReady) chk({txDiscontinue, txEcrcGen, txErrFwd, txLast, txStrobe, txPayload}, qTx.pop_front());
      asks += askOut;
      txReady <= 1'($random(seed));
   end
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   initial
   begin
      seed = 98967; rst = 1; {psel, penable, pwrite, paddr, pwdata, txReady} = '0;
      {srcPayload, srcKeep, srcByteEn, srcFirstStart, srcSecondStart, srcFirstEnd} = '0;
      {srcSecondEnd, srcEcrcErr, srcLast, srcValid, appPayload, appKeep} = '0;
      {appLast, appAbort, appValid, curPois, ctrl, expSt, fw, bc} = '0; ccFirst = 1;
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      apb(0, REG_CTRL, 0); chk(rd, CTRL_RESET);
      apb(1, REG_CTRL, 32'ha5a5_a5f3); apb(0, REG_CTRL, 0); chk(rd, 32'ha5a5_a5f3);
      chk(tallyOut, 2'h3);
      apb(1, REG_CTRL, 32'h4); repeat (4) @(posedge clk); chk(asks, 1);
      apb(0, 8'h10, 0); chk(er, 1);
      apb(1, REG_MASK, 0);
      for (int i = 0; i < 24; i++) rcBeat(i == 0);
      srcValid <= 0;
      repeat (10) @(posedge clk);
      chk(irq, 0);
      apb(0, REG_STATUS, 0); chk(rd, expSt);
      apb(0, REG_COUNT, 0); chk(rd, lastCnt);
      apb(1, REG_MASK, 7); repeat (2) @(posedge clk); chk(irq, 1);
      apb(1, REG_STATUS, 7); repeat (2) @(posedge clk); chk(irq, 0);
      for (int m = 0; m < 4; m++)
      begin
         ctrl = 2'(m);
         apb(1, REG_CTRL, m);
         for (int i = 0; i < 8; i++) ccBeat(i == 7);
         appValid <= 0;
      end
      repeat (100) @(posedge clk);
      chk(qRc.size() + qRx.size() + qTx.size(), 0);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
